// *** bench/qpio_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// port checks
module qpio_chk (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [4:0] addr_i,
   input wire logic rd_req_i,
   input wire logic wr_req_i,
   input wire logic [7:0] wdata_i,
   input wire logic dir_load_i,
   input wire logic [2:0] dir_sel_i,
   input wire logic [3:0] pin_a_i,
   input wire logic [7:0] pin_b_i,
   input wire logic [7:0] pin_b_o,
   input wire logic [3:0] pin_a_oe_o,
   input wire logic [7:0] pin_b_oe_o,
   input wire logic [1:0] phase_o,
   input wire logic rd_valid_o,
   input wire logic [7:0] rdata_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_phase_step: assert property (1 |=> phase_o == $past(phase_o) + 2'h1)
      else $error("phase order");
   a_read_pins: assert property (phase_o == 2'h1 && rd_req_i && addr_i == 5'h06
      |=> rd_valid_o && rdata_o == $past(pin_b_i)) else $error("read b");
   a_read_upper: assert property (phase_o == 2'h1 && rd_req_i && addr_i == 5'h05
      |=> rdata_o == {4'h0, $past(pin_a_i)}) else $error("read a");
   a_valid_cause: assert property (rd_valid_o |-> $past(phase_o) == 2'h1 && $past(rd_req_i))
      else $error("valid");
   a_dir_load: assert property (phase_o == 2'h3 && dir_load_i && dir_sel_i == 3'h6
      |=> pin_b_oe_o == ~$past(wdata_i)) else $error("dir load");
   a_dir_hold: assert property (!(phase_o == 2'h3 && dir_load_i && dir_sel_i == 3'h6)
      |=> $stable(pin_b_oe_o)) else $error("dir hold");
   a_write_latch: assert property (phase_o == 2'h3 && wr_req_i && addr_i == 5'h06
      |=> pin_b_o == $past(wdata_i)) else $error("latch");
   a_dir_reset: assert property ($rose(nrst_i) |-> pin_b_oe_o == 8'h00 && pin_a_oe_o == 4'h0)
      else $error("dir reset");
endmodule
`default_nettype wire

// *** bench/qpio_ext_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// pin wire level
module qpio_ext_model #(
   parameter W = 8
) (
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] out_i,
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] pin_o
);
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// *** bench/tb_qpio_ports.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// bench
module tb_qpio_ports;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic rd_req_i = 1'b0, wr_req_i = 1'b0, dir_load_i = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic [7:0] wdata_i = 8'h00, ext_b = 8'hA5, ext_c = 8'h3C;
   logic [3:0] ext_a = 4'hC;
   wire [3:0] pin_a_i, pin_a_o, pin_a_oe_o;
   wire [7:0] pin_b_i, pin_b_o, pin_b_oe_o, pin_c_i, pin_c_o, pin_c_oe_o, rdata_o;
   wire [1:0] phase_o;
   wire rd_valid_o;
   int err_count = 0, checked = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   qpio_ports u_dut (.dir_sel_i(addr_i[2:0]), .*);
   qpio_ext_model #(.W(4)) u_ext_a (.oe_i(pin_a_oe_o), .out_i(pin_a_o), .ext_i(ext_a),
      .pin_o(pin_a_i));
   qpio_ext_model u_ext_b (.oe_i(pin_b_oe_o), .out_i(pin_b_o), .ext_i(ext_b), .pin_o(pin_b_i));
   qpio_ext_model u_ext_c (.oe_i(pin_c_oe_o), .out_i(pin_c_o), .ext_i(ext_c), .pin_o(pin_c_i));
   task automatic complete_run(input bit hang);
      if (hang) err_count++;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // k is {read, write, direction load}
   task automatic op(input logic [1:0] p, input logic [2:0] k, input logic [4:0] a,
      input logic [7:0] d);
      int n;
      for (n = 0; n < 8; n++) begin
         @(negedge ref_clk_i);
         if (phase_o === p - 2'h1) break;
      end
      if (n == 8) complete_run(1'b1);
      @(posedge ref_clk_i);
      {rd_req_i, wr_req_i, dir_load_i} <= k;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      {rd_req_i, wr_req_i, dir_load_i} <= 3'h0;
      @(negedge ref_clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      op(2'h1, 3'h4, a, 8'h00);
      check("rdata", rdata_o, e);
      check("valid", {7'h00, rd_valid_o}, 8'h01);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      check("oe_b", pin_b_oe_o, 8'h00);
      rd(5'h06, 8'hA5);
      rd(5'h05, 8'h0C);
      rd(5'h07, 8'h3C);
      op(2'h3, 3'h2, 5'h06, 8'h5A);
      check("latch_b", pin_b_o, 8'h5A);
      rd(5'h06, 8'hA5);
      op(2'h3, 3'h1, 5'h06, 8'h0F);
      check("oe_b", pin_b_oe_o, 8'hF0);
      rd(5'h06, 8'h55);
      op(2'h3, 3'h1, 5'h05, 8'h00);
      check("oe_a", {4'h0, pin_a_oe_o}, 8'h0F);
      check("oe_b", pin_b_oe_o, 8'hF0);
      op(2'h3, 3'h2, 5'h07, 8'h81);
      op(2'h3, 3'h1, 5'h07, 8'h00);
      check("oe_c", pin_c_oe_o, 8'hFF);
      check("latch_c", pin_c_o, 8'h81);
      rd(5'h07, 8'h81);
      op(2'h3, 3'h2, 5'h05, 8'hF3);
      check("latch_a", {4'h0, pin_a_o}, 8'h03);
      rd(5'h05, 8'h03);
      op(2'h3, 3'h2, 5'h08, 8'hFF);
      op(2'h1, 3'h4, 5'h08, 8'h00);
      check("valid", {7'h00, rd_valid_o}, 8'h00);
      check("latch_b", pin_b_o, 8'h5A);
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("phase", {6'h00, phase_o}, 8'h01);
      check("oe_b", pin_b_oe_o, 8'h00);
      check("oe_c", pin_c_oe_o, 8'h00);
      check("latch_b", pin_b_o, 8'h5A);
      complete_run(1'b0);
   end
endmodule
bind qpio_ports qpio_chk u_chk (.*);
`default_nettype wire

// *** hw/qpio_consts.vh ***
`ifndef QPIO_CONSTS_VH
`define QPIO_CONSTS_VH
// ==========================================
// register addresses
`define QPIO_ADDR_A 5'h05
`define QPIO_ADDR_B 5'h06
`define QPIO_ADDR_C 5'h07
// ==========================================
// direction load selectors (low bits of operand)
`define QPIO_SEL_A 3'h5
`define QPIO_SEL_B 3'h6
`define QPIO_SEL_C 3'h7
// ==========================================
// reset values and widths
`define QPIO_DIR_RST 8'hFF
`define QPIO_A_WIDTH 4
`define QPIO_PHASES 4
// ==========================================
// phase codes
`define QPIO_PH_ONE 2'h0
`define QPIO_PH_TWO 2'h1
`define QPIO_PH_THREE 2'h2
`define QPIO_PH_FOUR 2'h3
`endif

// *** hw/qpio_phase_gen.v ***
`timescale 1ns/100ps
`default_nettype none
`include "qpio_consts.vh"
module qpio_phase_gen (
   input wire ref_clk_i,
   input wire nrst_i,
   output reg [1:0] phase_o,
   output wire phase_two_o,
   output wire phase_four_o
);
   // ==========================================
   // four-phase instruction cycle
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         phase_o <= `QPIO_PH_ONE;
      end else begin
         phase_o <= phase_o + 2'h1;
      end
   end
   assign phase_two_o = (phase_o == `QPIO_PH_TWO);
   assign phase_four_o = (phase_o == `QPIO_PH_FOUR);
endmodule
`default_nettype wire

// *** hw/qpio_pin_bank.v ***
`timescale 1ns/100ps
`default_nettype none
`include "qpio_consts.vh"
module qpio_pin_bank #(
   parameter WIDTH = 8
) (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire dir_load_i,
   input wire data_write_i,
   input wire [7:0] wdata_i,
   input wire [WIDTH-1:0] pin_i,
   output wire [WIDTH-1:0] pin_o,
   output wire [WIDTH-1:0] pin_oe_o,
   output wire [WIDTH-1:0] latch_o
);
   reg [WIDTH-1:0] direction_latch;
   reg [WIDTH-1:0] out_latch;
   // ==========================================
   // direction latch, write-only
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         direction_latch <= {WIDTH{1'b1}};
      end else if (dir_load_i) begin
         direction_latch <= wdata_i[WIDTH-1:0];
      end
   end
   // ==========================================
   // output data latch, no reset
   always @(posedge ref_clk_i) begin
      if (data_write_i) begin
         out_latch <= wdata_i[WIDTH-1:0];
      end
   end
   assign pin_o = out_latch;
   assign pin_oe_o = ~direction_latch;
   assign latch_o = out_latch;
endmodule
`default_nettype wire

// *** hw/qpio_ports.v ***
// Behaviour
// - port reads return live pin levels
// - reset sets all direction bits high
// - first port four pins, upper bits zero
// - second port eight pins, bits 7..0
// - third port optional, else plain register
// - direction load only for named port
// - one tristates pin, zero drives latch
// - direction registers have no read path
// - data addresses 05h, 06h, 07h
// - latches undefined at power, kept on reset
// - latches hold until rewritten
// - each pin direction set independently
// - instruction clock is four phases
// - reads phase two, writes phase four
`timescale 1ns/100ps
`default_nettype none
`include "qpio_consts.vh"
module qpio_ports #(
   parameter HAS_PORT_C = 1
) (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire [4:0] addr_i,
   input wire rd_req_i,
   input wire wr_req_i,
   input wire [7:0] wdata_i,
   input wire dir_load_i,
   input wire [2:0] dir_sel_i,
   input wire [3:0] pin_a_i,
   input wire [7:0] pin_b_i,
   input wire [7:0] pin_c_i,
   output wire [3:0] pin_a_o,
   output wire [3:0] pin_a_oe_o,
   output wire [7:0] pin_b_o,
   output wire [7:0] pin_b_oe_o,
   output wire [7:0] pin_c_o,
   output wire [7:0] pin_c_oe_o,
   output wire [1:0] phase_o,
   output reg rd_valid_o,
   output reg [7:0] rdata_o
);
   wire [1:0] phase;
   wire ph2;
   wire ph4;
   wire hit_a;
   wire hit_b;
   wire hit_c;
   wire [7:0] c_latch;
   wire [7:0] c_pin_o;
   wire [7:0] c_oe;
   reg [7:0] next_rdata;
   // ==========================================
   // phase generator
   qpio_phase_gen u_phase (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .phase_o(phase),
      .phase_two_o(ph2),
      .phase_four_o(ph4)
   );
   assign phase_o = phase;
   assign hit_a = (addr_i == `QPIO_ADDR_A);
   assign hit_b = (addr_i == `QPIO_ADDR_B);
   assign hit_c = (addr_i == `QPIO_ADDR_C);
   // ==========================================
   // port banks
   qpio_pin_bank #(.WIDTH(`QPIO_A_WIDTH)) u_a (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .dir_load_i(dir_load_i && ph4 && dir_sel_i == `QPIO_SEL_A),
      .data_write_i(wr_req_i && ph4 && hit_a),
      .wdata_i(wdata_i),
      .pin_i(pin_a_i),
      .pin_o(pin_a_o),
      .pin_oe_o(pin_a_oe_o),
      .latch_o()
   );
   qpio_pin_bank #(.WIDTH(8)) u_b (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .dir_load_i(dir_load_i && ph4 && dir_sel_i == `QPIO_SEL_B),
      .data_write_i(wr_req_i && ph4 && hit_b),
      .wdata_i(wdata_i),
      .pin_i(pin_b_i),
      .pin_o(pin_b_o),
      .pin_oe_o(pin_b_oe_o),
      .latch_o()
   );
   qpio_pin_bank #(.WIDTH(8)) u_c (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .dir_load_i(dir_load_i && ph4 && dir_sel_i == `QPIO_SEL_C && HAS_PORT_C != 0),
      .data_write_i(wr_req_i && ph4 && hit_c),
      .wdata_i(wdata_i),
      .pin_i(pin_c_i),
      .pin_o(c_pin_o),
      .pin_oe_o(c_oe),
      .latch_o(c_latch)
   );
   // without port c the latch is a general register, pins never driven
   assign pin_c_o = (HAS_PORT_C != 0) ? c_pin_o : 8'h00;
   assign pin_c_oe_o = (HAS_PORT_C != 0) ? c_oe : 8'h00;
   // ==========================================
   // read path: pins (port c output latch when HAS_PORT_C is 0), never direction latches
   always @* begin
      next_rdata = 8'h00;
      if (hit_a) begin
         next_rdata = {4'h0, pin_a_i};
      end else if (hit_b) begin
         next_rdata = pin_b_i;
      end else if (hit_c) begin
         next_rdata = (HAS_PORT_C != 0) ? pin_c_i : c_latch;
      end
   end
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_valid_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         rd_valid_o <= rd_req_i && ph2 && (hit_a || hit_b || hit_c);
         if (rd_req_i && ph2) begin
            rdata_o <= next_rdata;
         end
      end
   end
endmodule
`default_nettype wire
